// *** logic/pxsf_regs.sv ***
`timescale 1ns/1ps
// AXI4-Lite slave exposing the gigabit ability status and the feature control word.
module pxsf_regs
(
  // Clock and reset.
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // Write address channel.
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [11:0]             s_axi_awaddr,
  input  wire logic [2:0]              s_axi_awprot,
  // Write data channel.
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  // Write response channel.
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  output logic [1:0]                   s_axi_bresp,
  // Read address channel.
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  input  wire logic [11:0]             s_axi_araddr,
  input  wire logic [2:0]              s_axi_arprot,
  // Read data channel.
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  // PHY side.
  input  wire pxsf_pkg::pxsf_ability_t ability_strap,
  output logic                         pause_resolve_enable
);

  // Returns one when an address hits a mapped register.
  function automatic logic addr_mapped(input logic [11:0] a);
    addr_mapped = (a == pxsf_pkg::PXSF_ADDR_ABILITY) || (a == pxsf_pkg::PXSF_ADDR_FEATURE);
  endfunction

  // Timing as seen from the bus:
  //   edge N   : address and data are taken, together or one after the other;
  //   edge N+1 : the write reaches storage and the response is raised;
  //   later    : the response stands until the master takes it.
  // A read address taken at edge M is answered just after that edge with the
  // storage as it stood before the edge, and the answer stands until taken.
  // Address bits 1:0 are ignored, so every byte offset inside a word aliases
  // to that word. The protection bits are accepted and not checked: this
  // bank holds nothing that a privileged master alone may touch.
  // The readies are registered like every other bus output; they are worked
  // out from the next state, so a channel never takes a word a cycle late.

  // Write channel state.
  logic        aw_held_reg, aw_held_next;   // Address captured, waiting for data.
  logic        w_held_reg, w_held_next;     // Data captured, waiting for address.
  pxsf_pkg::pxsf_wreq_t wreq_reg, wreq_next; // Captured write.
  logic        bvalid_reg, bvalid_next;     // Response pending.
  logic [1:0]  bresp_reg, bresp_next;       // Response code.
  // Read channel state.
  logic        rvalid_reg, rvalid_next;     // Read data pending.
  logic [31:0] rdata_reg, rdata_next;       // Read data.
  logic [1:0]  rresp_reg, rresp_next;       // Read response code.
  // Decoded feature write.
  logic        feat_wr;                      // Write to the feature word, low lane.
  logic        pause_en;                     // Enable from storage.
  pxsf_pkg::pxsf_ability_t ability;          // Flags from storage.
  logic        do_write;                     // Both halves of a write present.
  // Ready flags, registered so that every bus output leaves a flip-flop.
  logic        awready_reg, awready_next;    // Address channel may take a word.
  logic        wready_reg, wready_next;      // Data channel may take a word.
  logic        arready_reg, arready_next;    // Read channel may take an address.

  pxsf_ability u_ability
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .strap   (ability_strap),
    .ability (ability)
  );

  pxsf_feature u_feature
  (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .wr_en    (feat_wr),
    .wr_bit   (wreq_reg.data[pxsf_pkg::PXSF_BIT_PAUSE_EN]),
    .pause_en (pause_en)
  );

  // Both halves of a write are present and the last answer has been taken.
  assign do_write      = aw_held_reg && w_held_reg && !bvalid_reg;
  // Only bit 0 of the feature word is writable; everything else is dropped.
  assign feat_wr = do_write && (wreq_reg.addr == pxsf_pkg::PXSF_ADDR_FEATURE)
                   && wreq_reg.strb[0];

  // Write path: capture address and data in either order, then respond.
  always_comb
  begin
    aw_held_next = aw_held_reg;
    w_held_next  = w_held_reg;
    wreq_next    = wreq_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_next  = 1'b1;
      wreq_next.addr = {s_axi_awaddr[11:2], 2'h0};
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_next    = 1'b1;
      wreq_next.data = s_axi_wdata;
      wreq_next.strb = s_axi_wstrb;
    end
    if (do_write)
    begin
      // Unmapped addresses get an error answer and change nothing.
      aw_held_next = 1'b0;
      w_held_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = addr_mapped(wreq_reg.addr) ? pxsf_pkg::PXSF_RESP_OKAY
                                                : pxsf_pkg::PXSF_RESP_SLVERR;
    end
    else if (bvalid_reg && s_axi_bready)
    begin
      bvalid_next = 1'b0;
    end
    // Ready only while the matching half is not yet held and no response waits,
    // so at most one write is under way; taken from the next state so that the
    // registered flag agrees with the state that it guards in every cycle.
    awready_next = !aw_held_next && !bvalid_next;
    wready_next  = !w_held_next && !bvalid_next;
  end

  // Read path: one read at a time; reads have no side effects.
  always_comb
  begin
    rvalid_next = rvalid_reg;
    rdata_next  = rdata_reg;
    rresp_next  = rresp_reg;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_next = 1'b1;
      rdata_next  = 32'h0000_0000;
      rresp_next  = pxsf_pkg::PXSF_RESP_OKAY;
      // Decode the word address; the data start from zero for every word.
      case ({s_axi_araddr[11:2], 2'h0})
        // Status word: the four flags, all other bits stay zero.
        pxsf_pkg::PXSF_ADDR_ABILITY:
        begin
          rdata_next[pxsf_pkg::PXSF_BIT_COPPER_HALF] = ability.gig_copper_half_able;
          rdata_next[pxsf_pkg::PXSF_BIT_COPPER_FULL] = ability.gig_copper_full_able;
          rdata_next[pxsf_pkg::PXSF_BIT_FIBER_HALF]  = ability.gig_fiber_half_able;
          rdata_next[pxsf_pkg::PXSF_BIT_FIBER_FULL]  = ability.gig_fiber_full_able;
        end
        // Feature word: the enable in bit 0, reserved bits zero.
        pxsf_pkg::PXSF_ADDR_FEATURE:
        begin
          rdata_next[pxsf_pkg::PXSF_BIT_PAUSE_EN] = pause_en;
        end
        // Unmapped words answer with an error and read as zero.
        default:
        begin
          rresp_next = pxsf_pkg::PXSF_RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_reg && s_axi_rready)
    begin
      rvalid_next = 1'b0;
    end
    // A new address is taken only once the last answer is gone.
    arready_next = !rvalid_next;
  end

  // Register all channel state.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      wreq_reg    <= '0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= pxsf_pkg::PXSF_RESP_OKAY;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= pxsf_pkg::PXSF_RESP_OKAY;
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      arready_reg <= 1'b1;
    end
    else
    begin
      aw_held_reg <= aw_held_next;
      w_held_reg  <= w_held_next;
      wreq_reg    <= wreq_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      arready_reg <= arready_next;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata  = rdata_reg;
  assign s_axi_rresp  = rresp_reg;
  assign pause_resolve_enable = pause_en;

  // Assertions, each kept beside the rule that it guards.

  // A decoded feature write lands in the enable on the next edge.
  a_feat_write_lands: assert property (@(posedge aclk) disable iff (!aresetn)
    feat_wr |=> pause_resolve_enable == $past(wreq_reg.data[pxsf_pkg::PXSF_BIT_PAUSE_EN]))
    else $error("pause enable did not take the written value");

  // Without a decoded write the enable holds; reads and other writes leave it alone.
  a_feat_stable: assert property (@(posedge aclk) disable iff (!aresetn)
    !feat_wr |=> $stable(pause_resolve_enable))
    else $error("pause enable changed without a write");

  // A status read returns the four flags in bits 15:12 and zero elsewhere.
  // The flags are held against the stored copy as it stood when the address was taken.
  a_ability_read: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == pxsf_pkg::PXSF_ADDR_ABILITY)
    |=> s_axi_rvalid && s_axi_rdata[11:0] == 12'h000 && s_axi_rdata[31:16] == 16'h0000
        && s_axi_rdata[15:12] == $past(ability))
    else $error("ability read returned wrong bits");

  // A feature read returns the enable in bit 0 and zero in the reserved bits.
  a_feat_read_rsvd: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == pxsf_pkg::PXSF_ADDR_FEATURE)
    |=> s_axi_rdata[31:1] == 31'h0 && s_axi_rdata[0] == $past(pause_resolve_enable))
    else $error("feature read returned wrong bits");

  // On the first edge after reset is released the flags show their power-on values.
  // The release itself is the trigger here, so these checks carry no disable clause.
  a_fiber_half_reset: assert property (@(posedge aclk)
    $rose(aresetn) |-> ability.gig_fiber_half_able && ability.gig_fiber_full_able)
    else $error("fiber ability flags not set after reset");

  // The fiber full-duplex flag comes out of reset set.
  a_fiber_full_reset: assert property (@(posedge aclk)
    $rose(aresetn) |-> ability.gig_fiber_full_able)
    else $error("fiber full ability not set after reset");

  // Both copper flags come out of reset clear.
  a_copper_reset: assert property (@(posedge aclk)
    $rose(aresetn) |-> !ability.gig_copper_half_able && !ability.gig_copper_full_able)
    else $error("copper ability flags not clear after reset");

  // The pause enable comes out of reset clear.
  a_pause_reset: assert property (@(posedge aclk)
    $rose(aresetn) |-> !pause_resolve_enable)
    else $error("pause enable not clear after reset");

  // Once both halves are held the answer is raised on the next edge and the
  // readies stay low until it has been taken, so one write at a time is under way.
  a_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
    else $error("write response missing");

  // A taken read address is answered on the next edge; no second one is taken meanwhile.
  a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer missing");

  // A read of an unmapped word answers with an error and all-zero data.
  a_unmapped_read: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready
     && {s_axi_araddr[11:2], 2'h0} != pxsf_pkg::PXSF_ADDR_ABILITY
     && {s_axi_araddr[11:2], 2'h0} != pxsf_pkg::PXSF_ADDR_FEATURE)
    |=> s_axi_rresp == pxsf_pkg::PXSF_RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");

  // A write to an unmapped word answers with an error and changes nothing.
  a_unmapped_write: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_write && wreq_reg.addr != pxsf_pkg::PXSF_ADDR_ABILITY
     && wreq_reg.addr != pxsf_pkg::PXSF_ADDR_FEATURE)
    |=> s_axi_bresp == pxsf_pkg::PXSF_RESP_SLVERR && $stable(pause_resolve_enable))
    else $error("unmapped write not refused");

  // A feature write without the low byte lane leaves the enable alone.
  a_strobe_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_write && wreq_reg.addr == pxsf_pkg::PXSF_ADDR_FEATURE && !wreq_reg.strb[0])
    |=> $stable(pause_resolve_enable))
    else $error("pause enable changed by a write without its lane");

  // A write to the read-only status word leaves the enable alone.
  a_status_write_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_write && wreq_reg.addr == pxsf_pkg::PXSF_ADDR_ABILITY)
    |=> $stable(pause_resolve_enable))
    else $error("status write changed the pause enable");

endmodule

// *** common/pxsf_pkg.sv ***
// Summary of operation
// - Bit 12 reads copper half-duplex gigabit ability.
// - Bit 13 reads copper full-duplex gigabit ability.
// - Bit 14 reads fiber half-duplex ability, resets one.
// - Bit 15 reads fiber full-duplex ability, resets one.
// - Feature bit 0 enables pause in resolution.
package pxsf_pkg;

  // Offsets are register indices; the byte address is four times the index.
  localparam logic [7:0] PXSF_IDX_ABILITY = 8'h0f;
  localparam logic [7:0] PXSF_IDX_FEATURE = 8'h10;
  localparam logic [11:0] PXSF_ADDR_ABILITY = 12'h03c;
  localparam logic [11:0] PXSF_ADDR_FEATURE = 12'h040;

  // Field positions.
  localparam int PXSF_BIT_COPPER_HALF = 12;
  localparam int PXSF_BIT_COPPER_FULL = 13;
  localparam int PXSF_BIT_FIBER_HALF  = 14;
  localparam int PXSF_BIT_FIBER_FULL  = 15;
  localparam int PXSF_BIT_PAUSE_EN    = 0;

  // Reset values.
  localparam logic       PXSF_RST_COPPER_HALF = 1'b0;
  localparam logic       PXSF_RST_COPPER_FULL = 1'b0;
  localparam logic       PXSF_RST_FIBER_HALF  = 1'b1;
  localparam logic       PXSF_RST_FIBER_FULL  = 1'b1;
  localparam logic       PXSF_RST_PAUSE_EN    = 1'b0;

  // Bus answers.
  localparam logic [1:0] PXSF_RESP_OKAY   = 2'h0;
  localparam logic [1:0] PXSF_RESP_SLVERR = 2'h2;

  // Ability flags carried as one group.
  typedef struct packed {
    logic gig_fiber_full_able;
    logic gig_fiber_half_able;
    logic gig_copper_full_able;
    logic gig_copper_half_able;
  } pxsf_ability_t;

  // Write request as taken from the bus.
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } pxsf_wreq_t;

endpackage

// *** logic/pxsf_ability.sv ***
`timescale 1ns/1ps
// Holds the ability flags; the strap inputs are captured by a clocked process.
module pxsf_ability
(
  // Clock and reset.
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // Ability straps from the PHY, same clock domain.
  input  wire pxsf_pkg::pxsf_ability_t strap,
  // Registered ability flags.
  output pxsf_pkg::pxsf_ability_t      ability
);

  pxsf_pkg::pxsf_ability_t ability_reg;   // Current flags.
  pxsf_pkg::pxsf_ability_t ability_next;  // Next flags.

  // The straps are tracked every cycle; reset loads the power-on values instead.
  always_comb
  begin
    ability_next = strap;
  end

  // Register stage; reset takes constants only.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ability_reg.gig_copper_half_able <= pxsf_pkg::PXSF_RST_COPPER_HALF;
      ability_reg.gig_copper_full_able <= pxsf_pkg::PXSF_RST_COPPER_FULL;
      ability_reg.gig_fiber_half_able  <= pxsf_pkg::PXSF_RST_FIBER_HALF;
      ability_reg.gig_fiber_full_able  <= pxsf_pkg::PXSF_RST_FIBER_FULL;
    end
    else
    begin
      ability_reg <= ability_next;
    end
  end

  assign ability = ability_reg;

endmodule

// *** logic/pxsf_feature.sv ***
`timescale 1ns/1ps
// Holds the pause resolution enable, written by software.
module pxsf_feature
(
  // Clock and reset.
  input  wire logic  aclk,
  input  wire logic  aresetn,
  // Write strobe and bit value, already decoded.
  input  wire logic  wr_en,
  input  wire logic  wr_bit,
  // Current enable.
  output logic       pause_en
);

  logic pause_en_reg;   // Stored enable.
  logic pause_en_next;  // Next enable.

  // Only a decoded write to the low lane changes the bit.
  always_comb
  begin
    pause_en_next = wr_en ? wr_bit : pause_en_reg;
  end

  // Register stage.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pause_en_reg <= pxsf_pkg::PXSF_RST_PAUSE_EN;
    end
    else
    begin
      pause_en_reg <= pause_en_next;
    end
  end

  assign pause_en = pause_en_reg;

endmodule

// *** verif/test_pxsf_regs.sv ***
`timescale 1ns/1ps
// Self-checking bench for the gigabit ability and feature registers.
module test_pxsf_regs;
  // Clock, reset and bus inputs, all driven by the bench.
  logic                    aclk          = 1'b0;
  logic                    aresetn       = 1'b0;
  logic                    s_axi_awvalid = 1'b0;
  logic                    s_axi_wvalid  = 1'b0;
  logic                    s_axi_bready  = 1'b0;
  logic                    s_axi_arvalid = 1'b0;
  logic                    s_axi_rready  = 1'b0;
  logic [11:0]             s_axi_awaddr  = 12'h000;
  logic [11:0]             s_axi_araddr  = 12'h000;
  logic [2:0]              s_axi_awprot  = 3'h0;
  logic [2:0]              s_axi_arprot  = 3'h0;
  logic [31:0]             s_axi_wdata   = 32'h0;
  logic [3:0]              s_axi_wstrb   = 4'h0;
  pxsf_pkg::pxsf_ability_t strap         = 4'hc;
  // Outputs of the design.
  logic                    s_axi_awready;
  logic                    s_axi_wready;
  logic                    s_axi_bvalid;
  logic                    s_axi_arready;
  logic                    s_axi_rvalid;
  logic [1:0]              s_axi_bresp;
  logic [1:0]              s_axi_rresp;
  logic [31:0]             s_axi_rdata;
  logic                    pause_resolve_enable;
  // Expected answers, oldest first, and the tallies.
  logic [33:0]             rq[$];
  logic [33:0]             bq[$];
  int                      n_errors      = 0;
  int                      cmp_count     = 0;
  int                      seed          = 6702;
  logic [31:0]             d;

  pxsf_regs dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .ability_strap(strap), .pause_resolve_enable(pause_resolve_enable));

  // A 100 ns clock.
  always #50 aclk = ~aclk;

  // Compares one value; case inequality so an unknown never passes.
  task automatic check(input logic [33:0] seen, input logic [33:0] expect_v);
    cmp_count++;
    if (seen !== expect_v)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: saw %h, wanted %h", $time, seen, expect_v);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic give_verdict;
    // Notes left over mean that an expected answer was never seen.
    if (rq.size() != 0 || bq.size() != 0)
      n_errors++;
    if (n_errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Offers address and data together and releases each once it is taken.
  task automatic axi_write(input logic [11:0] a, input logic [31:0] v,
                           input logic [3:0] s, input logic [1:0] resp);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done  = 1'b0;
    @(posedge aclk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr  <= a;
    s_axi_awprot  <= 3'($random(seed));
    s_axi_wvalid  <= 1'b1;
    s_axi_wdata   <= v;
    s_axi_wstrb   <= s;
    s_axi_bready  <= 1'b1;
    bq.push_back({resp, 32'h0});
    // No cycle count is assumed; only the watchdog ends a wait that never ends.
    while (!(aw_done && w_done))
    begin
      @(posedge aclk);
      if (!aw_done && s_axi_awready)
      begin
        s_axi_awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (!w_done && s_axi_wready)
      begin
        s_axi_wvalid <= 1'b0;
        w_done = 1'b1;
      end
    end
    // Bready stays high until the response is seen at an edge.
    while (!s_axi_bvalid)
      @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask

  // Reads one word and notes what the answer should carry.
  task automatic axi_read(input logic [11:0] a, input logic [33:0] expect_v);
    @(posedge aclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= a;
    s_axi_arprot  <= 3'($random(seed));
    s_axi_rready  <= 1'b1;
    rq.push_back(expect_v);
    // The address stands until an edge at which ready is sampled high.
    @(posedge aclk);
    while (!s_axi_arready)
      @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    // Rready stays high until the answer is seen at an edge.
    while (!s_axi_rvalid)
      @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask

  // Takes the oldest note off a queue whenever an answer is handed over.
  always @(posedge aclk)
  begin
    if (s_axi_rvalid && s_axi_rready)
      check({s_axi_rresp, s_axi_rdata}, rq.size() ? rq.pop_front() : 34'h3_ffff_ffff);
    if (s_axi_bvalid && s_axi_bready)
      check({s_axi_bresp, 32'h0}, bq.size() ? bq.pop_front() : 34'h3_ffff_ffff);
  end

  // Cuts a hang short; the whole sequence needs well under a thousand cycles.
  initial
  begin
    repeat (5000) @(posedge aclk);
    n_errors++;
    give_verdict();
  end

  // Main sequence.
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    // Out of reset all readies are high and the enable is clear.
    check({30'h0, s_axi_awready, s_axi_wready, s_axi_arready, pause_resolve_enable}, 34'he);
    // Straps hold the reset pattern, so the status reads fiber able, copper not.
    axi_read(pxsf_pkg::PXSF_ADDR_ABILITY, {2'h0, 32'h0000_c000});
    axi_read(pxsf_pkg::PXSF_ADDR_FEATURE, 34'h0);
    // Random straps and feature words; only bit 0 of the feature word may stick.
    repeat (8)
    begin
      @(posedge aclk);
      strap <= 4'($random(seed));
      d = $random(seed);
      axi_write(pxsf_pkg::PXSF_ADDR_FEATURE, d, 4'hf, pxsf_pkg::PXSF_RESP_OKAY);
      @(negedge aclk);
      check({33'h0, pause_resolve_enable}, {33'h0, d[0]});
      axi_read(pxsf_pkg::PXSF_ADDR_FEATURE, {33'h0, d[0]});
      // Writes to the status word change nothing; two reads in a row agree.
      axi_write(pxsf_pkg::PXSF_ADDR_ABILITY, ~d, 4'hf, pxsf_pkg::PXSF_RESP_OKAY);
      axi_read(pxsf_pkg::PXSF_ADDR_ABILITY, {18'h0, strap, 12'h0});
      axi_read(pxsf_pkg::PXSF_ADDR_ABILITY, {18'h0, strap, 12'h0});
    end
    // A write without the low byte lane leaves the enable alone.
    axi_write(pxsf_pkg::PXSF_ADDR_FEATURE, {31'h0, ~d[0]}, 4'he, pxsf_pkg::PXSF_RESP_OKAY);
    axi_read(pxsf_pkg::PXSF_ADDR_FEATURE, {33'h0, d[0]});
    // Unmapped places answer with an error and have no effect.
    axi_write(12'h100, {31'h0, ~d[0]}, 4'hf, pxsf_pkg::PXSF_RESP_SLVERR);
    axi_read(12'h100, {pxsf_pkg::PXSF_RESP_SLVERR, 32'h0});
    @(negedge aclk);
    check({33'h0, pause_resolve_enable}, {33'h0, d[0]});
    repeat (4) @(posedge aclk);
    give_verdict();
  end
endmodule
